// >>> design/fesc_host.sv
// Host controller that issues command sequences and polling reads to a parallel flash
//
// What this block does
// - Suspend is one write of B0, resume one write of 30, any address.
// - Host writes resume to leave suspension; erase then continues.
// - Multi-write commands open with AA at 555, then 55 at 2AA.
// - Program is unlock, A0 at 555, then byte at program address.
// - Erase is unlock, 80, unlock, then 10 at 555 or 30 at sector.
// - F0 at any address resets; needed to leave identification mode.
// - Host trusts the byte only on the read after the poll bit turns true.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fesc_regs.svh"

module fesc_host #(
    parameter int unsigned SUSPEND_CYC = `FESC_SUSPEND_US * `FESC_CLK_MHZ,
    parameter int unsigned WE_CYC      = `FESC_WE_CYC,
    parameter int unsigned HOLD_CYC    = `FESC_HOLD_CYC,
    parameter int unsigned RD_CYC      = `FESC_RD_CYC,
    parameter logic [15:0] POLL_MAX    = `FESC_POLL_MAX
) (
    input  wire logic          clock,        // 250 MHz clock
    input  wire logic          rst,          // Asynchronous reset, active high
    input  wire logic [3:0]    sw_addr,      // Register byte address
    input  wire logic [31:0]   sw_wdata,     // Register write data
    input  wire logic          sw_wr,        // Write strobe
    input  wire logic          sw_rd,        // Read strobe
    output logic [31:0]        sw_rdata,     // Read data, cycle after sw_rd
    output fesc_pkg::fesc_pins_t fl_pins,    // Flash address, data out, strobes
    input  wire logic [7:0]    fl_dq_in,     // Flash data pins as read
    input  wire logic          ready_busy_n  // Flash ready/busy pin
);

    fesc_pkg::fesc_ctx_t s_reg;
    fesc_pkg::fesc_ctx_t s_next;
    fesc_pkg::fesc_step_t cur;

    // Address and data of one bus cycle of a command sequence
    function automatic fesc_pkg::fesc_step_t cmd_step(
        input fesc_pkg::fesc_op_t op,
        input logic [2:0]         step,
        input logic [21:0]        addr,
        input logic [7:0]         data
    );
        fesc_pkg::fesc_step_t r;
        logic                 erase;
        r = '{rd: 1'b0, last: 1'b0, addr: `FESC_CMD_ADDR, data: `FESC_RESET_DATA};
        erase = (op == fesc_pkg::FESC_OP_CHIP) || (op == fesc_pkg::FESC_OP_SECT);
        unique case (op)
            fesc_pkg::FESC_OP_PROG, fesc_pkg::FESC_OP_CHIP,
            fesc_pkg::FESC_OP_SECT, fesc_pkg::FESC_OP_IDENT: begin
                if (step == `FESC_STEP_UNLOCK1 || (erase && step == `FESC_STEP_THIRD)) begin
                    r.addr = `FESC_UNLOCK1_ADDR;
                    r.data = `FESC_UNLOCK1_DATA;
                end else if (step == `FESC_STEP_UNLOCK2 || (erase && step == `FESC_STEP_FOURTH)) begin
                    r.addr = `FESC_UNLOCK2_ADDR;
                    r.data = `FESC_UNLOCK2_DATA;
                end else if (step == `FESC_STEP_CMD) begin
                    r.addr = `FESC_CMD_ADDR;
                    if (op == fesc_pkg::FESC_OP_PROG) begin
                        r.data = `FESC_PROG_DATA;
                    end else if (op == fesc_pkg::FESC_OP_IDENT) begin
                        r.data = `FESC_IDENT_DATA;
                    end else begin
                        r.data = `FESC_ERASE_DATA;
                    end
                end else if (op == fesc_pkg::FESC_OP_PROG) begin
                    r.addr = addr;
                    r.data = data;
                    r.last = 1'b1;
                end else if (op == fesc_pkg::FESC_OP_IDENT) begin
                    r.addr = addr;
                    r.rd   = 1'b1;
                    r.last = 1'b1;
                end else if (op == fesc_pkg::FESC_OP_CHIP) begin
                    r.data = `FESC_CHIP_DATA;
                    r.last = 1'b1;
                end else begin
                    r.addr = addr;
                    r.data = `FESC_SECTOR_DATA;
                    r.last = 1'b1;
                end
            end
            fesc_pkg::FESC_OP_ADDSECT: begin
                r.addr = addr;
                r.data = `FESC_SECTOR_DATA;
                r.last = 1'b1;
            end
            fesc_pkg::FESC_OP_SUSP: begin
                r.addr = addr;
                r.data = `FESC_SUSPEND_DATA;
                r.last = 1'b1;
            end
            fesc_pkg::FESC_OP_RESUME: begin
                r.addr = addr;
                r.data = `FESC_RESUME_DATA;
                r.last = 1'b1;
            end
            fesc_pkg::FESC_OP_RESET: begin
                r.addr = addr;
                r.last = 1'b1;
            end
            default: begin
                r.addr = addr;
                r.rd   = 1'b1;
                r.last = 1'b1;
            end
        endcase
        return r;
    endfunction

    assign cur = cmd_step(s_reg.op, s_reg.step, s_reg.addr, s_reg.data);

    always_comb begin
        s_next = s_reg;
        s_next.dq_s1 = fl_dq_in;
        s_next.dq_s2 = s_reg.dq_s1;
        s_next.rb_s1 = ready_busy_n;
        s_next.rb_s2 = s_reg.rb_s1;

        if (sw_rd) begin
            unique case (sw_addr)
                `FESC_REG_ADDR:   s_next.rdata = {10'h000, s_reg.addr};
                `FESC_REG_DATA:   s_next.rdata = {24'h000000, s_reg.rbyte};
                `FESC_REG_STATUS: begin
                    s_next.rdata = 32'h00000000;
                    s_next.rdata[`FESC_ST_BUSY]  = s_reg.busy;
                    s_next.rdata[`FESC_ST_DONE]  = s_reg.done;
                    s_next.rdata[`FESC_ST_FAIL]  = s_reg.fail;
                    s_next.rdata[`FESC_ST_READY] = s_reg.rb_s2;
                end
                `FESC_REG_CMD:    s_next.rdata = {28'h0000000, s_reg.op};
                default:          s_next.rdata = 32'h00000000;
            endcase
        end

        if (sw_wr && !s_reg.busy) begin
            if (sw_addr == `FESC_REG_ADDR) begin
                s_next.addr = sw_wdata[21:0];
            end else if (sw_addr == `FESC_REG_DATA) begin
                s_next.data = sw_wdata[7:0];
            end
        end

        unique case (s_reg.state)
            fesc_pkg::FESC_IDLE: begin
                if (sw_wr && sw_addr == `FESC_REG_CMD) begin
                    s_next.op    = fesc_pkg::fesc_op_t'(sw_wdata[3:0]);
                    s_next.step  = `FESC_STEP_UNLOCK1;
                    s_next.pcnt  = 16'h0000;
                    s_next.seen  = 1'b0;
                    s_next.busy  = 1'b1;
                    s_next.done  = 1'b0;
                    s_next.fail  = 1'b0;
                    s_next.state = fesc_pkg::FESC_SETUP;
                end
            end
            fesc_pkg::FESC_SETUP: begin
                // Address and chip select settle one cycle before the write strobe falls; on reads OE falls with them
                s_next.pins.addr = cur.addr;
                s_next.pins.ce_n = 1'b0;
                if (cur.rd) begin
                    s_next.pins.oe_n = 1'b0;
                    s_next.cnt       = 16'(RD_CYC);
                    s_next.state     = fesc_pkg::FESC_RDSTB;
                end else begin
                    s_next.pins.dq    = cur.data;
                    s_next.pins.dq_oe = 1'b1;
                    s_next.state      = fesc_pkg::FESC_STROBE;
                    s_next.cnt        = 16'(WE_CYC);
                end
            end
            fesc_pkg::FESC_STROBE: begin
                s_next.pins.we_n = 1'b0;
                s_next.cnt       = s_reg.cnt - 16'h0001;
                if (s_reg.cnt == 16'h0001) begin
                    // Data and address stay past the rising edge
                    s_next.pins.we_n = 1'b1;
                    s_next.cnt       = 16'(HOLD_CYC);
                    s_next.state     = fesc_pkg::FESC_HOLD;
                end
            end
            fesc_pkg::FESC_HOLD: begin
                s_next.cnt = s_reg.cnt - 16'h0001;
                if (s_reg.cnt == 16'h0001) begin
                    s_next.pins.ce_n  = 1'b1;
                    s_next.pins.dq_oe = 1'b0;
                    s_next.state      = fesc_pkg::FESC_NEXT;
                end
            end
            fesc_pkg::FESC_RDSTB: begin
                // Count covers access time plus the two-stage input sync
                s_next.cnt = s_reg.cnt - 16'h0001;
                if (s_reg.cnt == 16'h0001) begin
                    s_next.rbyte     = s_reg.dq_s2;
                    s_next.pins.oe_n = 1'b1;
                    s_next.pins.ce_n = 1'b1;
                    s_next.state     = fesc_pkg::FESC_NEXT;
                end
            end
            fesc_pkg::FESC_NEXT: begin
                s_next.state = fesc_pkg::FESC_IDLE;
                if (!cur.last) begin
                    s_next.step  = s_reg.step + 3'h1;
                    s_next.state = fesc_pkg::FESC_SETUP;
                end else if (s_reg.op == fesc_pkg::FESC_OP_POLL) begin
                    // Expected top bit: programmed byte, or 1 for erase or suspend
                    if (s_reg.rbyte[7] == s_reg.data[7]) begin
                        s_next.seen = 1'b1;
                        if (!s_reg.seen) begin
                            s_next.state = fesc_pkg::FESC_SETUP;
                        end
                    end else begin
                        s_next.seen = 1'b0;
                        s_next.pcnt = s_reg.pcnt + 16'h0001;
                        if (s_reg.pcnt == POLL_MAX) begin
                            s_next.fail = 1'b1;
                        end else begin
                            s_next.state = fesc_pkg::FESC_SETUP;
                        end
                    end
                end else if (s_reg.op == fesc_pkg::FESC_OP_SUSP) begin
                    s_next.cnt   = 16'(SUSPEND_CYC);
                    s_next.state = fesc_pkg::FESC_DELAY;
                end
                if (s_next.state == fesc_pkg::FESC_IDLE) begin
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                end
            end
            fesc_pkg::FESC_DELAY: begin
                s_next.cnt = s_reg.cnt - 16'h0001;
                if (s_reg.cnt <= 16'h0001) begin
                    s_next.busy  = 1'b0;
                    s_next.done  = 1'b1;
                    s_next.state = fesc_pkg::FESC_IDLE;
                end
            end
            default: begin
                s_next.busy  = 1'b0;
                s_next.state = fesc_pkg::FESC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg           <= '0;
            s_reg.pins.ce_n <= 1'b1;
            s_reg.pins.we_n <= 1'b1;
            s_reg.pins.oe_n <= 1'b1;
            s_reg.rb_s1     <= 1'b1;
            s_reg.rb_s2     <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sw_rdata = s_reg.rdata;
    assign fl_pins  = s_reg.pins;

endmodule

`default_nettype wire

// >>> design/fesc_regs.svh
// Address, data, register map and timing constants of the flash command host
`ifndef FESC_REGS_SVH
`define FESC_REGS_SVH

// Flash command encodings
`define FESC_UNLOCK1_ADDR  22'h000555
`define FESC_UNLOCK2_ADDR  22'h0002AA
`define FESC_CMD_ADDR      22'h000555
`define FESC_UNLOCK1_DATA  8'hAA
`define FESC_UNLOCK2_DATA  8'h55
`define FESC_PROG_DATA     8'hA0
`define FESC_ERASE_DATA    8'h80
`define FESC_CHIP_DATA     8'h10
`define FESC_SECTOR_DATA   8'h30
`define FESC_RESUME_DATA   8'h30
`define FESC_SUSPEND_DATA  8'hB0
`define FESC_RESET_DATA    8'hF0
`define FESC_IDENT_DATA    8'h90

// Controller register byte offsets
`define FESC_REG_CMD       4'h0
`define FESC_REG_ADDR      4'h4
`define FESC_REG_DATA      4'h8
`define FESC_REG_STATUS    4'hC

// Status register bit positions
`define FESC_ST_BUSY       0
`define FESC_ST_DONE       1
`define FESC_ST_FAIL       2
`define FESC_ST_READY      3

// Sequence step numbers
`define FESC_STEP_UNLOCK1  3'h0
`define FESC_STEP_UNLOCK2  3'h1
`define FESC_STEP_CMD      3'h2
`define FESC_STEP_THIRD    3'h3
`define FESC_STEP_FOURTH   3'h4
`define FESC_STEP_SIXTH    3'h5

// Timing
`define FESC_CLK_MHZ       250
`define FESC_SUSPEND_US    20
`define FESC_WE_CYC        10
`define FESC_HOLD_CYC      4
`define FESC_RD_CYC        25
`define FESC_POLL_MAX      16'hFFFF

`endif

// >>> design/fesc_pkg.sv
// Types of the flash command host
package fesc_pkg;

    typedef enum logic [3:0] {
        FESC_OP_READ    = 4'h0,
        FESC_OP_RESET   = 4'h1,
        FESC_OP_PROG    = 4'h2,
        FESC_OP_CHIP    = 4'h3,
        FESC_OP_SECT    = 4'h4,
        FESC_OP_ADDSECT = 4'h5,
        FESC_OP_SUSP    = 4'h6,
        FESC_OP_RESUME  = 4'h7,
        FESC_OP_IDENT   = 4'h8,
        FESC_OP_POLL    = 4'h9
    } fesc_op_t;

    typedef enum logic [2:0] {
        FESC_IDLE   = 3'h0,
        FESC_SETUP  = 3'h1,
        FESC_STROBE = 3'h3,
        FESC_HOLD   = 3'h2,
        FESC_NEXT   = 3'h6,
        FESC_RDSTB  = 3'h7,
        FESC_DELAY  = 3'h5
    } fesc_state_t;

    typedef struct packed {
        logic        rd;
        logic        last;
        logic [21:0] addr;
        logic [7:0]  data;
    } fesc_step_t;

    typedef struct packed {
        logic [21:0] addr;
        logic [7:0]  dq;
        logic        dq_oe;
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
    } fesc_pins_t;

    typedef struct packed {
        fesc_state_t state;
        fesc_op_t    op;
        logic [2:0]  step;
        logic [15:0] cnt;
        logic [15:0] pcnt;
        logic        seen;
        logic [21:0] addr;
        logic [7:0]  data;
        logic [7:0]  rbyte;
        logic        busy;
        logic        done;
        logic        fail;
        logic [31:0] rdata;
        fesc_pins_t  pins;
        logic [7:0]  dq_s1;
        logic [7:0]  dq_s2;
        logic        rb_s1;
        logic        rb_s2;
    } fesc_ctx_t;

endpackage

// >>> verification/fesc_host_checker.sv
// Concurrent checks on the flash pins and software port of the command host
`timescale 1ns/1ps
`default_nettype none
module fesc_host_checker #(
    parameter int unsigned WE_CYC   = 10,
    parameter int unsigned HOLD_CYC = 4
) (
    input wire logic                 clock,        // Host clock
    input wire logic                 rst,          // Async reset, high
    input wire logic [3:0]           sw_addr,      // Register address
    input wire logic                 sw_rd,        // Read strobe
    input wire logic [31:0]          sw_rdata,     // Read data
    input wire fesc_pkg::fesc_pins_t fl_pins,      // Flash pins
    input wire logic                 ready_busy_n  // Flash ready pin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [15:0] low_cnt;

    // Counts sampled cycles of a low write strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            low_cnt <= 16'h0000;
        end else if (!fl_pins.we_n) begin
            low_cnt <= low_cnt + 16'h0001;
        end else begin
            low_cnt <= 16'h0000;
        end
    end

    // Strobe stays low one cycle short of WE_CYC, the first count being its setup
    sequence s_pulse;
        fl_pins.we_n && low_cnt == 16'(WE_CYC - 1);
    endsequence
    sequence s_hold;
        (!fl_pins.ce_n && fl_pins.dq_oe)[*4];
    endsequence

    property p_wr_sel;
        $fell(fl_pins.we_n) |-> !fl_pins.ce_n && fl_pins.dq_oe && fl_pins.oe_n;
    endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("write strobe without select");
    property p_pulse;
        $rose(fl_pins.we_n) |-> s_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse length wrong");
    property p_hold;
        $rose(fl_pins.we_n) |-> s_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("data not held after strobe");
    property p_stable;
        !fl_pins.we_n |-> $stable(fl_pins.addr) && $stable(fl_pins.dq);
    endproperty
    a_stable: assert property (p_stable) else $error("address or data moved in pulse");
    property p_unl1;
        $fell(fl_pins.we_n) && fl_pins.dq == 8'hAA |-> fl_pins.addr[10:0] == 11'h555;
    endproperty
    a_unl1: assert property (p_unl1) else $error("first unlock at wrong address");
    property p_unl2;
        $fell(fl_pins.we_n) && fl_pins.dq == 8'h55 |-> fl_pins.addr[10:0] == 11'h2AA;
    endproperty
    a_unl2: assert property (p_unl2) else $error("second unlock at wrong address");
    property p_cmd;
        $fell(fl_pins.we_n) && (fl_pins.dq == 8'hA0 || fl_pins.dq == 8'h80)
            |-> fl_pins.addr[10:0] == 11'h555;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command at wrong address");
    property p_rd;
        !fl_pins.oe_n |-> fl_pins.we_n && !fl_pins.dq_oe && !fl_pins.ce_n;
    endproperty
    a_rd: assert property (p_rd) else $error("read cycle collides with drive");
    property p_ready;
        sw_rd && sw_addr == 4'hC && $stable(ready_busy_n) && $past(ready_busy_n, 2) == ready_busy_n
            && $past(ready_busy_n, 4) == ready_busy_n |=> sw_rdata[3] == $past(ready_busy_n);
    endproperty
    a_ready: assert property (p_ready) else $error("ready bit differs from pin");
endmodule

bind fesc_host fesc_host_checker #(.WE_CYC(WE_CYC), .HOLD_CYC(HOLD_CYC)) u_chk (
    .clock(clock), .rst(rst), .sw_addr(sw_addr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .fl_pins(fl_pins), .ready_busy_n(ready_busy_n));
`default_nettype wire

// >>> verification/fesc_flash_model.sv
// Behavioural flash device answering the host's command sequences
`timescale 1ns/1ps
`default_nettype none
module fesc_flash_model #(
    parameter logic [7:0] MAKER_CODE  = 8'h5C,  // Arbitrary maker code
    parameter logic [7:0] DEVICE_CODE = 8'hC3   // Arbitrary device code
) (
    input  wire fesc_pkg::fesc_pins_t pins,         // Host pins
    output logic [7:0]                dq_out,       // Data seen by host
    output logic                      ready_busy_n  // Pulled up when ready
);
    logic [21:0] log_a[$];
    logic [7:0]  log_d[$];
    logic [21:0] lat_a;
    logic [21:0] prog_a = 22'h3FFFFF;
    logic [7:0]  prog_d = 8'hFF;
    logic [5:0]  sect = 6'h3F;
    logic [7:0]  rd;
    int          mode = 0;  // 0 read, 1 program, 2 sector erase, 3 suspended, 4 chip erase
    bit          ident = 1'b0;
    time         done_at;

    function automatic bit hit(int k, logic [10:0] a, logic [7:0] d);
        int n = log_a.size();
        return n > k && log_a[n-1-k][10:0] == a && log_d[n-1-k] == d;
    endfunction

    always @(negedge pins.we_n) lat_a = pins.addr;
    always @(posedge pins.we_n) begin
        if (pins.ce_n == 1'b0) begin
            log_a.push_back(lat_a);
            log_d.push_back(pins.dq);
            if (mode == 2 && pins.dq == 8'hB0) begin
                mode = 3;
            end else if (mode == 3 && pins.dq == 8'h30) begin
                mode = 2;
            end else if (mode == 0 && hit(1, 11'h555, 8'hA0) && hit(2, 11'h2AA, 8'h55)
                         && hit(3, 11'h555, 8'hAA)) begin
                prog_a = lat_a;
                prog_d = pins.dq;
                done_at = $time + 2000;
                mode = 1;
            end else if (mode == 0 && pins.dq == 8'h30 && hit(1, 11'h2AA, 8'h55)
                         && hit(3, 11'h555, 8'h80) && hit(5, 11'h555, 8'hAA)) begin
                sect = lat_a[21:16];
                mode = 2;
            end else if (mode == 0 && pins.dq == 8'h10 && hit(1, 11'h2AA, 8'h55)
                         && hit(3, 11'h555, 8'h80) && hit(5, 11'h555, 8'hAA)) begin
                done_at = $time + 4000;
                mode = 4;
            end
            if (pins.dq == 8'hF0) ident = 1'b0;
            if ((mode == 0 || mode == 3) && pins.dq == 8'h90 && hit(1, 11'h2AA, 8'h55)
                && hit(2, 11'h555, 8'hAA)) ident = 1'b1;
        end
    end

    always #40 if ((mode == 1 || mode == 4) && $time >= done_at) mode = 0;

    always @* begin
        if (ident) rd = (pins.addr[7:0] == 8'h00) ? MAKER_CODE
                      : (pins.addr[7:0] == 8'h01) ? DEVICE_CODE : 8'h00;
        else if (mode == 4) rd = 8'h00;
        else if (mode == 1 && pins.addr == prog_a) rd = {~prog_d[7], 7'h00};
        else if (mode >= 2 && pins.addr[21:16] == sect) rd = {mode == 3, 7'h00};
        else if (pins.addr == prog_a) rd = prog_d;
        else rd = pins.addr[7:0] ^ 8'h5A;
        // Released bus shows the inverse so a stale value never passes
        dq_out = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
    end
    assign ready_busy_n = !(mode == 1 || mode == 2 || mode == 4);
endmodule
`default_nettype wire

// >>> verification/fesc_host_test.sv
// Self-checking bench of the flash command host
`timescale 1ns/1ps
`default_nettype none
`include "fesc_regs.svh"
module fesc_host_test;
    logic                 clock = 1'b0;
    logic                 rst = 1'b1;
    logic [3:0]           sw_addr = 4'h0;
    logic [31:0]          sw_wdata = 32'h0;
    logic                 sw_wr = 1'b0;
    logic                 sw_rd = 1'b0;
    logic [31:0]          sw_rdata;
    fesc_pkg::fesc_pins_t pins;
    logic [7:0]           dq_in;
    logic                 rbn;
    logic [31:0]          rv;
    int                   fail_count = 0;
    int                   total_checks = 0;
    int                   base;
    localparam logic [21:0] PA = 22'h123456;
    localparam logic [21:0] SA = 22'h2A0100;

    fesc_host #(.SUSPEND_CYC(20), .POLL_MAX(16'h0400)) dut (.clock(clock), .rst(rst),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .fl_pins(pins), .fl_dq_in(dq_in), .ready_busy_n(rbn));
    fesc_flash_model flash (.pins(pins), .dq_out(dq_in), .ready_busy_n(rbn));

    initial forever #2 clock = ~clock;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clock);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge clock);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask

    // Starts one operation and waits, bounded, until the host is idle again
    task automatic run_op(input fesc_pkg::fesc_op_t op, input logic [21:0] a, input logic [7:0] d);
        base = flash.log_a.size();
        sw_write(`FESC_REG_ADDR, {10'h000, a});
        sw_write(`FESC_REG_DATA, {24'h000000, d});
        sw_write(`FESC_REG_CMD, {28'h0000000, op});
        for (int i = 0; i < 20000; i++) begin
            sw_read(`FESC_REG_STATUS, rv);
            if (rv[`FESC_ST_BUSY] === 1'b0) return;
        end
        cmp("host idle", 32'h0, rv);
        report_and_stop();
    endtask

    task automatic chk_wr(input int i, input logic [21:0] a, input logic [7:0] d);
        cmp("flash write address", {10'h000, a}, {10'h000, flash.log_a[base + i]});
        cmp("flash write data", {24'h000000, d}, {24'h000000, flash.log_d[base + i]});
    endtask

    task automatic chk_unlock(input int i);
        chk_wr(i, 22'h000555, 8'hAA);
        chk_wr(i + 1, 22'h0002AA, 8'h55);
    endtask

    task automatic t_idle;
        cmp("idle strobes", 32'h7, {29'h0, pins.ce_n, pins.we_n, pins.oe_n});
        sw_read(4'h2, rv);
        cmp("unmapped read", 32'h0, rv);
    endtask

    task automatic t_program;
        run_op(fesc_pkg::FESC_OP_PROG, PA, 8'h3C);
        cmp("program writes", 32'd4, flash.log_a.size() - base);
        chk_unlock(0);
        chk_wr(2, 22'h000555, 8'hA0);
        chk_wr(3, PA, 8'h3C);
        cmp("ready while programming", 32'h0, rv[`FESC_ST_READY]);
        run_op(fesc_pkg::FESC_OP_POLL, PA, 8'h3C);
        sw_read(`FESC_REG_DATA, rv);
        cmp("polled byte", 32'h3C, rv);
        sw_read(`FESC_REG_STATUS, rv);
        cmp("done and no fail", 32'h2, rv & 32'h6);
        sw_read(`FESC_REG_ADDR, rv);
        cmp("address readback", {10'h000, PA}, rv);
        sw_read(`FESC_REG_CMD, rv);
        cmp("command readback", 32'h9, rv);
        run_op(fesc_pkg::FESC_OP_POLL, 22'h000025, 8'h80);
        cmp("poll gives up", 32'h6, rv & 32'h6);
    endtask

    task automatic t_chip;
        run_op(fesc_pkg::FESC_OP_CHIP, 22'h0000A5, 8'h80);
        cmp("chip erase writes", 32'd6, flash.log_a.size() - base);
        chk_wr(2, 22'h000555, 8'h80);
        chk_unlock(3);
        chk_wr(5, 22'h000555, 8'h10);
        run_op(fesc_pkg::FESC_OP_SUSP, 22'h000000, 8'h00);
        cmp("suspend ignored in chip erase", 32'h0, rv[`FESC_ST_READY]);
        run_op(fesc_pkg::FESC_OP_POLL, 22'h0000A5, 8'h80);
        sw_read(`FESC_REG_DATA, rv);
        cmp("erased byte", 32'hFF, rv);
    endtask

    task automatic t_erase;
        run_op(fesc_pkg::FESC_OP_SECT, SA, 8'h00);
        cmp("erase writes", 32'd6, flash.log_a.size() - base);
        chk_unlock(0);
        chk_wr(2, 22'h000555, 8'h80);
        chk_unlock(3);
        chk_wr(5, SA, 8'h30);
        run_op(fesc_pkg::FESC_OP_ADDSECT, 22'h2B0000, 8'h00);
        chk_wr(0, 22'h2B0000, 8'h30);
        run_op(fesc_pkg::FESC_OP_SUSP, 22'h3FF000, 8'h00);
        chk_wr(0, 22'h3FF000, 8'hB0);
        cmp("ready when suspended", 32'h1, rv[`FESC_ST_READY]);
        run_op(fesc_pkg::FESC_OP_POLL, SA, 8'h80);
        sw_read(`FESC_REG_DATA, rv);
        cmp("suspended sector status", 32'h1, rv[7]);
        run_op(fesc_pkg::FESC_OP_READ, 22'h100042, 8'h00);
        sw_read(`FESC_REG_DATA, rv);
        cmp("array read while suspended", 32'h18, rv);
        run_op(fesc_pkg::FESC_OP_IDENT, 22'h2A0102, 8'h00);
        sw_read(`FESC_REG_DATA, rv);
        cmp("group protect code", 32'h0, rv);
        run_op(fesc_pkg::FESC_OP_RESET, 22'h0ABCDE, 8'h00);
        chk_wr(0, 22'h0ABCDE, 8'hF0);
        run_op(fesc_pkg::FESC_OP_POLL, SA, 8'h80);
        sw_read(`FESC_REG_DATA, rv);
        cmp("suspended again after ident", 32'h80, rv);
        run_op(fesc_pkg::FESC_OP_RESUME, 22'h155555, 8'h00);
        chk_wr(0, 22'h155555, 8'h30);
        cmp("busy after resume", 32'h0, rv[`FESC_ST_READY]);
        run_op(fesc_pkg::FESC_OP_RESUME, 22'h155555, 8'h00);
        cmp("second resume ignored", 32'h0, rv[`FESC_ST_READY]);
        run_op(fesc_pkg::FESC_OP_SUSP, 22'h000000, 8'h00);
        cmp("suspend after resume", 32'h1, rv[`FESC_ST_READY]);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_idle();
        t_chip();
        t_program();
        t_erase();
        report_and_stop();
    end
endmodule
`default_nettype wire
